// *** src/cadc_cfg_if.sv ***
// carries the decoded configuration between the control modules
// assumes one clock domain
`timescale 1ns/1ns
`default_nettype none
interface cadc_cfg_if;
  cadc_pkg::cadc_cfg_t cfg;
  logic                cfg_load;
  modport src (output cfg, output cfg_load);
  modport dst (input cfg, input cfg_load);
endinterface : cadc_cfg_if
`default_nettype wire

// *** src/cadc_ctrl.sv ***
// acquisition and conversion sequencer for a charge-integrating converter
// assumes strobe, reset and config pins are asynchronous to I_CORE_CLK
// Summary of operation
// - twelve-bit word: acq, ovs, intg, range, format
// - acquisition interval opens every integration for acq codes 10/11
// - one reset clock, then 0/15/31 acquisition clocks
// - offset cancel on except code none
// - initial point subtracted from final point
// - integrations averaged; period is count times length
// - acq codes 00 none, 01/10/11 1/16/32
// - counts decode power of two, top bit 256
`timescale 1ns/1ns
`default_nettype none
`include "cadc_regs.svh"
module cadc_ctrl (
  input  wire logic          I_CORE_CLK,
  input  wire logic          I_SYS_RST,
  input  wire logic          I_RESET_SYSTEM_N,
  input  wire logic          I_INTEGRATION_FRAME_STROBE_N,
  input  wire logic          I_CFG_CLK,
  input  wire logic          I_CFG_DATA,
  input  wire logic [19:0]   I_SAMPLE,
  input  wire logic          I_SAMPLE_VALID,
  output var  logic          O_INTEG_RESET,
  output var  logic          O_ACQUIRE,
  output var  logic          O_SAMPLE_INITIAL,
  output var  logic          O_SAMPLE_FINAL,
  output var  logic          O_OFFSET_CANCEL_SAMPLING,
  output var  logic          O_BIPOLAR,
  output var  logic          O_TWOS_COMPLEMENT,
  output var  logic [20:0]   O_RESULT,
  output var  logic          O_RESULT_VALID,
  output var  logic          O_RUNNING
);
  import cadc_pkg::*;

  // decoded count: codes 0..7 give 2**code, top bit gives 256
  function automatic logic [8:0] cadc_pow_count(input logic [3:0] code);
    if (code[3]) begin
      cadc_pow_count = 9'h100;
    end else begin
      cadc_pow_count = 9'(9'h001 << code[2:0]);
    end
  endfunction : cadc_pow_count

  typedef struct packed {
    logic [1:0]  rst_sync;
    logic [1:0]  fds_sync;
    logic [1:0]  cclk_sync;
    logic [1:0]  cdat_sync;
    logic        cclk_prev;
    logic        fds_prev;
    logic        running;
    cadc_state_t state;
    logic [4:0]  acq_cnt;
    logic [8:0]  os_cnt;
    logic [8:0]  intg_cnt;
    logic [29:0] init_acc;
    logic [29:0] fin_acc;
    logic [38:0] conv_acc;
    logic        integ_reset;
    logic        acquire;
    logic        samp_init;
    logic        samp_fin;
    logic [20:0] result;
    logic        result_valid;
  } cadc_ctrl_t;

  cadc_ctrl_t st;
  cadc_ctrl_t next_st;
  cadc_cfg_if cfg_bus ();

  logic        sys_reset;
  logic        fds_active;
  logic        cds_on;
  logic [4:0]  acq_clks;
  logic [8:0]  ovs_n;
  logic [8:0]  intg_n;
  logic [29:0] fin_now;
  logic [29:0] diff;
  logic [38:0] avg;

  assign sys_reset  = ~st.rst_sync[1];
  assign fds_active = ~st.fds_sync[1];

  cadc_setup_shift u_shift (
    .i_clk          (I_CORE_CLK),
    .i_rst          (I_SYS_RST),
    .i_cfg_clk_rise (st.cclk_sync[1] & ~st.cclk_prev),
    .i_cfg_bit      (st.cdat_sync[1]),
    .i_sys_reset    (sys_reset),
    .cfg_bus        (cfg_bus.src)
  );

  always_comb begin
    cds_on = (cfg_bus.cfg.acq != `CADC_ACQ_NONE);
    unique case (cfg_bus.cfg.acq)
      `CADC_ACQ_K16: acq_clks = `CADC_ACQ_CLK_K16;
      `CADC_ACQ_K32: acq_clks = `CADC_ACQ_CLK_K32;
      default:       acq_clks = 5'h00;
    endcase
    ovs_n  = cadc_pow_count(cfg_bus.cfg.ovs);
    intg_n = cadc_pow_count(cfg_bus.cfg.intg);
    // sum includes the sample arriving now, so the last final point is not lost
    fin_now = 30'(st.fin_acc + {10'h000, I_SAMPLE});
    diff   = cds_on ? 30'(fin_now - st.init_acc) : fin_now;
    avg    = 39'(st.conv_acc + {{9{diff[29] & cds_on}}, diff});
  end

  always_comb begin
    next_st = st;
    next_st.rst_sync  = {st.rst_sync[0], I_RESET_SYSTEM_N};
    next_st.fds_sync  = {st.fds_sync[0], I_INTEGRATION_FRAME_STROBE_N};
    next_st.cclk_sync = {st.cclk_sync[0], I_CFG_CLK};
    next_st.cdat_sync = {st.cdat_sync[0], I_CFG_DATA};
    next_st.cclk_prev = st.cclk_sync[1];
    next_st.fds_prev  = fds_active;
    next_st.integ_reset  = 1'b0;
    next_st.acquire      = 1'b0;
    next_st.samp_init    = 1'b0;
    next_st.samp_fin     = 1'b0;
    next_st.result_valid = 1'b0;
    if (sys_reset) begin
      next_st.running  = 1'b0;
      next_st.state    = CADC_IDLE;
      next_st.intg_cnt = 9'h000;
      next_st.conv_acc = '0;
    end else if (!st.running) begin
      if (!fds_active && st.fds_prev) begin
        next_st.running = 1'b1;
      end
    end
    // strobe falling edge (going active) opens each integration
    if (!sys_reset && st.running && fds_active && !st.fds_prev) begin
      next_st.state       = CADC_RST;
      next_st.integ_reset = 1'b1;
      next_st.acq_cnt     = 5'h00;
    end else if (!sys_reset && st.running) begin
      unique case (st.state)
        CADC_IDLE: ;
        CADC_RST: begin
          next_st.os_cnt   = 9'h000;
          next_st.init_acc = '0;
          next_st.fin_acc  = '0;
          if (acq_clks != 5'h00) begin
            next_st.state   = CADC_ACQ;
            next_st.acquire = 1'b1;
          end else begin
            next_st.state = cds_on ? CADC_INITP : CADC_MEAS;
          end
        end
        CADC_ACQ: begin
          next_st.acq_cnt = 5'(st.acq_cnt + 5'h01);
          if (5'(st.acq_cnt + 5'h01) >= acq_clks) begin
            next_st.state = cds_on ? CADC_INITP : CADC_MEAS;
          end else begin
            next_st.acquire = 1'b1;
          end
        end
        CADC_INITP: begin
          if (I_SAMPLE_VALID) begin
            next_st.samp_init = 1'b1;
            next_st.init_acc  = 30'(st.init_acc + {10'h000, I_SAMPLE});
            next_st.os_cnt    = 9'(st.os_cnt + 9'h001);
            if (9'(st.os_cnt + 9'h001) == ovs_n) begin
              next_st.state  = CADC_MEAS;
              next_st.os_cnt = 9'h000;
            end
          end
        end
        CADC_MEAS: begin
          // integration ends when the strobe returns inactive
          if (!fds_active && st.fds_prev) begin
            next_st.state = CADC_FINP;
          end
        end
        CADC_FINP: begin
          if (I_SAMPLE_VALID) begin
            next_st.samp_fin = 1'b1;
            next_st.fin_acc  = fin_now;
            next_st.os_cnt   = 9'(st.os_cnt + 9'h001);
            if (9'(st.os_cnt + 9'h001) == ovs_n) begin
              next_st.state    = CADC_IDLE;
              next_st.intg_cnt = 9'(st.intg_cnt + 9'h001);
              next_st.conv_acc = avg;
              if (9'(st.intg_cnt + 9'h001) == intg_n) begin
                // divide by M*L, both powers of two
                next_st.result = 21'((avg >>> (cfg_bus.cfg.ovs[3] ? 4'h8 : {1'b0, cfg_bus.cfg.ovs[2:0]}))
                  >>> (cfg_bus.cfg.intg[3] ? 4'h8 : {1'b0, cfg_bus.cfg.intg[2:0]}));
                next_st.result_valid = 1'b1;
                next_st.intg_cnt     = 9'h000;
                next_st.conv_acc     = '0;
              end
            end
          end
        end
        default: next_st.state = CADC_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      O_OFFSET_CANCEL_SAMPLING <= 1'b0;
      O_BIPOLAR                <= 1'b0;
      O_TWOS_COMPLEMENT        <= 1'b0;
    end else if (cfg_bus.cfg_load) begin
      // levels change only as a new word lands, never mid-shift
      O_OFFSET_CANCEL_SAMPLING <= cds_on;
      O_BIPOLAR                <= cfg_bus.cfg.bipolar;
      O_TWOS_COMPLEMENT        <= cfg_bus.cfg.twos;
    end
  end

  assign O_INTEG_RESET    = st.integ_reset;
  assign O_ACQUIRE        = st.acquire;
  assign O_SAMPLE_INITIAL = st.samp_init;
  assign O_SAMPLE_FINAL   = st.samp_fin;
  assign O_RESULT         = st.result;
  assign O_RESULT_VALID   = st.result_valid;
  assign O_RUNNING        = st.running;
endmodule : cadc_ctrl
`default_nettype wire

// *** src/cadc_pkg.sv ***
// types for the charge converter setup and acquisition control
// assumes cadc_regs.svh supplies the numeric constants
`default_nettype none
package cadc_pkg;
  typedef enum logic [2:0] {
    CADC_IDLE  = 3'b000,
    CADC_RST   = 3'b001,
    CADC_ACQ   = 3'b011,
    CADC_INITP = 3'b010,
    CADC_MEAS  = 3'b110,
    CADC_FINP  = 3'b100
  } cadc_state_t;

  typedef struct packed {
    logic [1:0] acq;
    logic [3:0] ovs;
    logic [3:0] intg;
    logic       bipolar;
    logic       twos;
  } cadc_cfg_t;
endpackage : cadc_pkg
`default_nettype wire

// *** src/cadc_regs.svh ***
// constants for the charge converter setup and acquisition control
// assumes inclusion by bare name from design files
`ifndef CADC_REGS_SVH
`define CADC_REGS_SVH
`define CADC_CFG_WIDTH      12
`define CADC_CFG_RESET      12'h000
`define CADC_ACQ_MSB        11
`define CADC_ACQ_LSB        10
`define CADC_OVS_MSB        9
`define CADC_OVS_LSB        6
`define CADC_INTG_MSB       5
`define CADC_INTG_LSB       2
`define CADC_RANGE_BIT      1
`define CADC_FMT_BIT        0
`define CADC_ACQ_NONE       2'h0
`define CADC_ACQ_K1         2'h1
`define CADC_ACQ_K16        2'h2
`define CADC_ACQ_K32        2'h3
`define CADC_ACQ_CLK_K16    5'h0F
`define CADC_ACQ_CLK_K32    5'h1F
`define CADC_RESET_CLKS     1
`endif

// *** src/cadc_setup_shift.sv ***
// serial shifter for the 12-bit configuration word
// assumes cfg pins already synchronised; shifting allowed only while system reset is high, word load only after it drops
`timescale 1ns/1ns
`default_nettype none
`include "cadc_regs.svh"
module cadc_setup_shift (
  input  wire logic    i_clk,
  input  wire logic    i_rst,
  input  wire logic    i_cfg_clk_rise,
  input  wire logic    i_cfg_bit,
  input  wire logic    i_sys_reset,
  cadc_cfg_if.src      cfg_bus
);
  import cadc_pkg::*;

  typedef struct packed {
    logic [`CADC_CFG_WIDTH-1:0] shreg;
    logic [`CADC_CFG_WIDTH-1:0] word;
    logic                       load;
  } cadc_shift_t;

  cadc_shift_t st;
  cadc_shift_t next_st;

  always_comb begin
    next_st = st;
    next_st.load = 1'b0;
    if (i_sys_reset && i_cfg_clk_rise) begin
      // first bit in ends at the top: acquisition msb leads
      next_st.shreg = {st.shreg[`CADC_CFG_WIDTH-2:0], i_cfg_bit};
    end
    if (!i_sys_reset && st.load == 1'b0 && st.word != st.shreg) begin
      next_st.word = st.shreg;
      next_st.load = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '{shreg: `CADC_CFG_RESET, word: `CADC_CFG_RESET, load: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign cfg_bus.cfg = '{acq:     st.word[`CADC_ACQ_MSB:`CADC_ACQ_LSB],
                         ovs:     st.word[`CADC_OVS_MSB:`CADC_OVS_LSB],
                         intg:    st.word[`CADC_INTG_MSB:`CADC_INTG_LSB],
                         bipolar: st.word[`CADC_RANGE_BIT],
                         twos:    st.word[`CADC_FMT_BIT]};
  assign cfg_bus.cfg_load = st.load;
endmodule : cadc_setup_shift
`default_nettype wire

// *** verification/cadc_ctrl_chk.sv ***
// concurrent checks on the acquisition sequencer ports
// assumes binding onto cadc_ctrl, one clock domain
`timescale 1ns/1ns
`default_nettype none
module cadc_ctrl_chk (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_SYS_RST,
  input  wire logic        I_SAMPLE_VALID,
  input  wire logic        O_INTEG_RESET,
  input  wire logic        O_ACQUIRE,
  input  wire logic        O_SAMPLE_INITIAL,
  input  wire logic        O_SAMPLE_FINAL,
  input  wire logic        O_OFFSET_CANCEL_SAMPLING,
  input  wire logic [20:0] O_RESULT,
  input  wire logic        O_RESULT_VALID,
  input  wire logic        O_RUNNING
);
  logic [5:0] run;
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);
  // length of the current acquire run, read on its falling edge
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST || !O_ACQUIRE) run <= 6'h00;
    else run <= run + 6'h01;
  end
  sequence one_reset_clk;
    O_INTEG_RESET ##1 !O_INTEG_RESET;
  endsequence
  sequence acq_hold;
    O_ACQUIRE [*8];
  endsequence
  rst_one_clk_a: assert property (O_INTEG_RESET |-> one_reset_clk)
    else $error("reset clock not one cycle");
  acq_start_a: assert property ($rose(O_ACQUIRE) |-> $past(O_INTEG_RESET) ##0 acq_hold)
    else $error("acquire not after reset clock");
  acq_len_a: assert property ($fell(O_ACQUIRE) |-> run == 6'h0F || run == 6'h1F)
    else $error("acquire length wrong");
  no_cds_init_a: assert property (!O_OFFSET_CANCEL_SAMPLING |-> !O_SAMPLE_INITIAL)
    else $error("initial point without offset cancel");
  init_accept_a: assert property (O_SAMPLE_INITIAL |-> $past(I_SAMPLE_VALID))
    else $error("initial point without sample");
  final_accept_a: assert property (O_SAMPLE_FINAL |-> $past(I_SAMPLE_VALID))
    else $error("final point without sample");
  res_after_fin_a: assert property (O_RESULT_VALID |-> O_SAMPLE_FINAL || $past(O_SAMPLE_FINAL))
    else $error("result not after final point");
  res_hold_a: assert property (!O_RESULT_VALID |-> $stable(O_RESULT))
    else $error("result moved without valid");
  run_gate_a: assert property (!O_RUNNING |-> !O_INTEG_RESET)
    else $error("integration before run start");
endmodule : cadc_ctrl_chk
bind cadc_ctrl cadc_ctrl_chk u_chk (.I_CORE_CLK(I_CORE_CLK), .I_SYS_RST(I_SYS_RST),
  .I_SAMPLE_VALID(I_SAMPLE_VALID), .O_INTEG_RESET(O_INTEG_RESET), .O_ACQUIRE(O_ACQUIRE),
  .O_SAMPLE_INITIAL(O_SAMPLE_INITIAL), .O_SAMPLE_FINAL(O_SAMPLE_FINAL),
  .O_OFFSET_CANCEL_SAMPLING(O_OFFSET_CANCEL_SAMPLING), .O_RESULT(O_RESULT),
  .O_RESULT_VALID(O_RESULT_VALID), .O_RUNNING(O_RUNNING));
`default_nettype wire

// *** verification/cadc_host.sv ***
// host controller model: setup load, reset release, frame strobe
// assumes tasks are called from the bench on the core clock
`timescale 1ns/1ns
`default_nettype none
module cadc_host (
  input  wire logic i_clk,
  output var  logic o_rst_n,
  output var  logic o_strobe_n,
  output var  logic o_cfg_clk,
  output var  logic o_cfg_data
);
  initial begin
    o_rst_n = 1'b0;
    o_strobe_n = 1'b0;
    o_cfg_clk = 1'b0;
    o_cfg_data = 1'b0;
  end
  // slow serial clock so the two-flop sync sees every level
  task automatic setup(input logic [11:0] word);
    @(posedge i_clk);
    o_rst_n <= 1'b0;
    o_strobe_n <= 1'b0;
    for (int i = 11; i >= 0; i--) begin
      o_cfg_data <= word[i];
      repeat (5) @(posedge i_clk);
      o_cfg_clk <= 1'b1;
      repeat (5) @(posedge i_clk);
      o_cfg_clk <= 1'b0;
    end
    o_cfg_data <= ~word[0];
    repeat (5) @(posedge i_clk);
    o_rst_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    o_strobe_n <= 1'b1;
    repeat (5) @(posedge i_clk);
  endtask : setup
  task automatic strobe(input logic lvl);
    @(posedge i_clk);
    o_strobe_n <= lvl;
  endtask : strobe
endmodule : cadc_host
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the charge converter sequencer
// assumes cadc_host as far side and the bound checker
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rst_n, stb_n, cfg_clk, cfg_data;
  logic [19:0] smp = 20'h00000;
  logic        smp_v = 1'b0;
  logic        irst, acq_o, s_ini, s_fin, ocs, bip, twos, res_v, running;
  logic [20:0] res;
  int          failures = 0;
  int          n_tests = 0;
  int          n_ini = 0;
  int          n_fin = 0;
  int          n_irst = 0;
  always #4 clk = ~clk;
  // pulse tallies; each pulse stands one cycle, so one edge counts it once
  always @(posedge clk) begin
    if (s_ini === 1'b1) n_ini <= n_ini + 1;
    if (s_fin === 1'b1) n_fin <= n_fin + 1;
    if (irst === 1'b1) n_irst <= n_irst + 1;
  end
  cadc_host host (.i_clk(clk), .o_rst_n(rst_n), .o_strobe_n(stb_n), .o_cfg_clk(cfg_clk),
    .o_cfg_data(cfg_data));
  cadc_ctrl dut (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_RESET_SYSTEM_N(rst_n),
    .I_INTEGRATION_FRAME_STROBE_N(stb_n), .I_CFG_CLK(cfg_clk), .I_CFG_DATA(cfg_data),
    .I_SAMPLE(smp), .I_SAMPLE_VALID(smp_v), .O_INTEG_RESET(irst), .O_ACQUIRE(acq_o),
    .O_SAMPLE_INITIAL(s_ini), .O_SAMPLE_FINAL(s_fin), .O_OFFSET_CANCEL_SAMPLING(ocs),
    .O_BIPOLAR(bip), .O_TWOS_COMPLEMENT(twos), .O_RESULT(res), .O_RESULT_VALID(res_v),
    .O_RUNNING(running));
  task automatic check(input logic [20:0] seen, input logic [20:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // n sample pulses two cycles apart; sgn weights them into the model sum
  task automatic feed(input int n, inout longint acc, input int sgn);
    logic [19:0] d;
    for (int i = 0; i < n; i++) begin
      d = 20'($urandom);
      @(posedge clk);
      smp <= d;
      smp_v <= 1'b1;
      @(posedge clk);
      smp_v <= 1'b0;
      smp <= ~d;
      acc = acc + sgn * longint'(d);
    end
  endtask : feed
  task automatic run(input logic [1:0] acq, input logic [3:0] mc, input logic [3:0] lc,
                     input logic rng, input logic fmt);
    int     m, l, k, sh, i0, f0, r0;
    longint acc, junk;
    m = mc[3] ? 256 : (1 << mc[2:0]);
    l = lc[3] ? 256 : (1 << lc[2:0]);
    k = (acq == 2'h3) ? 31 : (acq == 2'h2) ? 15 : 0;
    sh = $clog2(m * l);
    acc = 0;
    junk = 0;
    i0 = n_ini;
    f0 = n_fin;
    r0 = n_irst;
    host.setup({acq, mc, lc, rng, fmt});
    check(ocs, acq != 2'h0);
    check(bip, rng);
    check(twos, fmt);
    check(running, 1'b1);
    for (int i = 0; i < l; i++) begin
      host.strobe(1'b0);
      repeat (4) @(posedge clk);
      // pulses inside acquisition must be ignored
      if (k != 0) feed(2, junk, 0);
      repeat (k + 2) @(posedge clk);
      feed(m, acc, (acq != 2'h0) ? -1 : 0);
      feed(1, junk, 0);
      host.strobe(1'b1);
      repeat (4) @(posedge clk);
      feed(m, acc, 1);
    end
    for (int t = 0; t < 20 && res_v !== 1'b1; t++) @(negedge clk);
    check(res_v, 1'b1);
    check(res, 21'(acc >>> sh));
    // one more edge so the tally has seen the last final pulse
    @(negedge clk);
    check(21'(n_ini - i0), 21'((acq != 2'h0) ? m * l : 0));
    check(21'(n_fin - f0), 21'(m * l));
    check(21'(n_irst - r0), 21'(l));
  endtask : run
  initial begin
    // roughly ten times the expected length of all runs
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end
  initial begin
    void'($urandom(72));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    run(2'h2, 4'h1, 4'h1, 1'b0, 1'b1);
    run(2'h0, 4'h0, 4'h2, 1'b1, 1'b0);
    run(2'h3, 4'h8 | 4'($urandom), 4'h0, 1'b1, 1'b1);
    run(2'h1, 4'h2, 4'h3, 1'b0, 1'b0);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
